// >>> design/rcnc_pkg.sv
// Constants, field layouts and carrier types of the receiver configuration
// and end-of-stream noise control block.
// Assumes one 125 MHz core clock and an active-low asynchronous reset.
package rcnc_pkg;

    localparam int unsigned CLK_MHZ        = 125;
    localparam int unsigned FRAME_BITS     = 15;
    localparam int unsigned PAYLOAD_W      = 12;
    localparam int unsigned SLEEP_UNIT_CYC = 1024;
    localparam logic [4:0]  SLEEP_FOREVER  = 5'h1F;
    localparam logic [5:0]  LIM_MIN_FLOOR  = 6'h0A;
    // Start-up settle time and end pulse unit, in ns
    localparam int unsigned T_STARTUP_NS   = 1000;
    localparam int unsigned T_PULSE_NS     = 64;
    localparam int unsigned STARTUP_CYC    =
        (T_STARTUP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PULSE_UNIT_CYC =
        (T_PULSE_NS * CLK_MHZ + 999) / 1000;

    // Operating register, payload bit 11 is frame bit 3
    typedef struct packed {
        logic [1:0] baud_band;
        logic [1:0] check_count;
        logic       modulation_select;
        logic [4:0] sleep_count;
        logic       sleep_stretch;
        logic       noise_quiet;
    } rcnc_opset_s;

    // Limit register, lower limit in frame bits 3-8
    typedef struct packed {
        logic [5:0] lim_lower;
        logic [5:0] lim_upper;
    } rcnc_limit_s;

    localparam rcnc_opset_s OPSET_DEFAULT = 12'h119;
    localparam rcnc_limit_s LIMIT_DEFAULT = 12'h569;

    // One-cycle result of a received frame
    typedef struct packed {
        logic                 off_cmd;
        logic                 load_op;
        logic                 load_lim;
        logic [PAYLOAD_W-1:0] payload;
    } rcnc_frame_s;

    typedef enum logic [2:0] {
        RCNC_SLEEP   = 3'b000,
        RCNC_STARTUP = 3'b001,
        RCNC_BITCHK  = 3'b010,
        RCNC_RECV    = 3'b011,
        RCNC_ENDPLS  = 3'b100
    } rcnc_mode_e;

endpackage

// >>> design/rcnc_frame_rx.sv
// Shifts in 15-bit configuration frames taken from the DATA line.
// Assumes an outside bit timer marks frame start and each bit sample.
`timescale 1ns/100ps
module rcnc_frame_rx (
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          nrst,
    // Sampled data line and bit timing
    input  wire logic          frame_start,
    input  wire logic          bit_stb,
    input  wire logic          dline_in,
    // Decoded frame event
    output rcnc_pkg::rcnc_frame_s frame_evt
);
    import rcnc_pkg::*;

    typedef struct packed {
        logic [13:0] shreg;
        logic [3:0]  cnt;
        logic        busy;
        rcnc_frame_s evt;
    } rcnc_frx_s;

    rcnc_frx_s st_ff;
    rcnc_frx_s nxt_st;

    // Frame bit 1 arrives first and ends up in shreg[13]
    always_comb begin
        nxt_st = st_ff;
        nxt_st.evt = '0;
        if (frame_start) begin
            nxt_st.busy = 1'b1;
            nxt_st.cnt  = 4'h0;
        end else if (bit_stb && st_ff.busy) begin
            nxt_st.cnt = st_ff.cnt + 4'h1;
            if (st_ff.cnt == 4'h0 && dline_in) begin
                // OFF needs no payload, so act on bit 1 at once
                nxt_st.evt.off_cmd = 1'b1;
                nxt_st.busy = 1'b0;
            end else if (st_ff.cnt == 4'(FRAME_BITS - 1)) begin
                nxt_st.busy = 1'b0;
                // Stop bit must be 0 for the payload to land
                if (!dline_in) begin
                    nxt_st.evt.load_op  = st_ff.shreg[12];
                    nxt_st.evt.load_lim = !st_ff.shreg[12];
                    nxt_st.evt.payload  = st_ff.shreg[11:0];
                end
            end else begin
                nxt_st.shreg = {st_ff.shreg[12:0], dline_in};
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign frame_evt = st_ff.evt;

endmodule

// >>> design/rcnc_sleep_timer.sv
// Sleep timer: count times stretch times a 1024-cycle unit.
// Assumes start is a one-cycle pulse; count 0 finishes at once.
`timescale 1ns/100ps
module rcnc_sleep_timer #(
    parameter int unsigned UNIT_CYC = rcnc_pkg::SLEEP_UNIT_CYC
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       nrst,
    // Control
    input  wire logic       start,
    input  wire logic [4:0] sleep_count,
    input  wire logic       sleep_stretch,
    // Elapsed pulse
    output logic            done
);
    import rcnc_pkg::*;

    typedef struct packed {
        logic [7:0]  units;
        logic [15:0] sub;
        logic        run;
        logic        done;
    } rcnc_slp_s;

    rcnc_slp_s st_ff;
    rcnc_slp_s nxt_st;

    // Units count down once per UNIT_CYC clocks
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        if (start) begin
            nxt_st.units = sleep_stretch ? {sleep_count, 3'h0}
                                         : {3'h0, sleep_count};
            nxt_st.sub  = '0;
            nxt_st.run  = (sleep_count != 5'h00);
            nxt_st.done = (sleep_count == 5'h00);
        end else if (st_ff.run) begin
            nxt_st.sub = st_ff.sub + 16'h0001;
            if (st_ff.sub == 16'(UNIT_CYC - 1)) begin
                nxt_st.sub   = '0;
                nxt_st.units = st_ff.units - 8'h01;
                if (st_ff.units == 8'h01) begin
                    nxt_st.run  = 1'b0;
                    nxt_st.done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign done = st_ff.done;

endmodule

// >>> design/rcnc_top.sv
// Configuration registers and end-of-stream noise control of a polled
// receiver. Frames from the host arrive on the DATA line; the block
// sequences sleep, start-up, bit-check and receiving modes.
// Assumes bit timing, bit check and demodulation sit outside and are
// synchronous to core_clk.
`timescale 1ns/100ps
module rcnc_top #(
    parameter int unsigned STARTUP_CYC    = rcnc_pkg::STARTUP_CYC,
    parameter int unsigned PULSE_UNIT_CYC = rcnc_pkg::PULSE_UNIT_CYC,
    parameter int unsigned SLEEP_UNIT_CYC = rcnc_pkg::SLEEP_UNIT_CYC
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              nrst,
    // DATA line, open-drain style
    input  wire logic              dline_in,
    output logic                   dline_out,
    output logic                   dline_oe,
    // Frame bit timing from the line timer
    input  wire logic              frame_start,
    input  wire logic              bit_stb,
    // Polling override pin, low keeps the block out of sleep
    input  wire logic              polling_on_n,
    // Demodulator and bit-check status
    input  wire logic              demod_data,
    input  wire logic              stream_end,
    input  wire logic              last_high,
    input  wire logic              chk_ok,
    input  wire logic              chk_fail,
    input  wire logic              supply_dip,
    // Mode and settings seen by the rest of the receiver
    output rcnc_pkg::rcnc_mode_e   mode,
    output logic                   ic_active,
    output logic                   supply_dip_pattern,
    output logic                   modulation_select,
    output logic [3:0]             check_bits,
    output logic [3:0]             limit_scale,
    output logic [8:0]             lim_min_cyc,
    output logic [8:0]             lim_max_cyc,
    output logic                   lim_min_bad
);
    import rcnc_pkg::*;

    typedef struct packed {
        rcnc_mode_e  mode;
        rcnc_opset_s op;
        rcnc_limit_s lim;
        logic [15:0] cnt;
        logic        slp_start;
        logic        rm;
        logic        op_ok;
        logic        lim_ok;
        logic        dout;
        logic        doe;
        logic [3:0]  chk_bits;
        logic [3:0]  scale;
        logic [8:0]  lmin;
        logic [8:0]  lmax;
        logic        lbad;
        logic        act;
    } rcnc_top_s;

    rcnc_top_s   st_ff;
    rcnc_top_s   nxt_st;
    rcnc_frame_s frame_evt;
    logic        slp_done;

    // Baud band to bit-check limit scale
    function automatic logic [3:0] scale_of(input logic [1:0] band);
        case (band)
            2'h0:    scale_of = 4'h8;
            2'h1:    scale_of = 4'h4;
            2'h2:    scale_of = 4'h2;
            default: scale_of = 4'h1;
        endcase
    endfunction

    // Check count field to number of bits checked
    function automatic logic [3:0] bits_of(input logic [1:0] cc);
        case (cc)
            2'h0:    bits_of = 4'h0;
            2'h1:    bits_of = 4'h3;
            2'h2:    bits_of = 4'h6;
            default: bits_of = 4'h9;
        endcase
    endfunction

    rcnc_frame_rx u_frame_rx (
        .core_clk    (core_clk),
        .nrst        (nrst),
        .frame_start (frame_start),
        .bit_stb     (bit_stb),
        .dline_in    (dline_in),
        .frame_evt   (frame_evt)
    );

    rcnc_sleep_timer #(
        .UNIT_CYC (SLEEP_UNIT_CYC)
    ) u_sleep_timer (
        .core_clk      (core_clk),
        .nrst          (nrst),
        .start         (st_ff.slp_start),
        .sleep_count   (st_ff.op.sleep_count),
        .sleep_stretch (st_ff.op.sleep_stretch),
        .done          (slp_done)
    );

    // Register loads, reset marker and mode sequencing
    always_comb begin
        logic [15:0] pulse_len;
        nxt_st = st_ff;
        pulse_len = 16'(PULSE_UNIT_CYC) * {12'h000, st_ff.scale};
        nxt_st.slp_start = 1'b0;

        // Frame writes into the two registers
        if (frame_evt.load_op) begin
            nxt_st.op    = frame_evt.payload;
            nxt_st.op_ok = 1'b1;
        end
        if (frame_evt.load_lim) begin
            nxt_st.lim    = frame_evt.payload;
            nxt_st.lim_ok = 1'b1;
        end
        // Marker drops once both registers were rewritten
        if (nxt_st.op_ok && nxt_st.lim_ok) begin
            nxt_st.rm = 1'b0;
        end
        // A dip wins over a same-cycle write: contents are untrusted
        if (supply_dip) begin
            nxt_st.op     = OPSET_DEFAULT;
            nxt_st.lim    = LIMIT_DEFAULT;
            nxt_st.rm     = 1'b1;
            nxt_st.op_ok  = 1'b0;
            nxt_st.lim_ok = 1'b0;
        end

        case (st_ff.mode)
            RCNC_SLEEP: begin
                // Override low forces start-up whatever the sleep
                if (!polling_on_n) begin
                    nxt_st.mode = RCNC_STARTUP;
                    nxt_st.cnt  = '0;
                end else if (slp_done &&
                             st_ff.op.sleep_count != SLEEP_FOREVER) begin
                    nxt_st.mode = RCNC_STARTUP;
                    nxt_st.cnt  = '0;
                end
            end
            RCNC_STARTUP: begin
                nxt_st.cnt = st_ff.cnt + 16'h0001;
                if (st_ff.cnt == 16'(STARTUP_CYC - 1)) begin
                    nxt_st.cnt  = '0;
                    // No bits to check means straight to receiving
                    nxt_st.mode = (st_ff.chk_bits == 4'h0) ? RCNC_RECV
                                                           : RCNC_BITCHK;
                end
            end
            RCNC_BITCHK: begin
                if (chk_ok) begin
                    nxt_st.mode = RCNC_RECV;
                end else if (chk_fail) begin
                    // Override low skips sleep and retries at once
                    nxt_st.mode = polling_on_n ? RCNC_SLEEP
                                               : RCNC_STARTUP;
                    nxt_st.slp_start = polling_on_n;
                    nxt_st.cnt = '0;
                end
            end
            RCNC_RECV: begin
                if (frame_evt.off_cmd) begin
                    nxt_st.mode = polling_on_n ? RCNC_SLEEP
                                               : RCNC_STARTUP;
                    nxt_st.slp_start = polling_on_n;
                    nxt_st.cnt = '0;
                end else if (stream_end && last_high) begin
                    nxt_st.mode = RCNC_ENDPLS;
                    nxt_st.cnt  = '0;
                end else if (stream_end && st_ff.op.noise_quiet) begin
                    nxt_st.mode = RCNC_BITCHK;
                end
                // Quiet bit clear: stay here, noise passes
            end
            RCNC_ENDPLS: begin
                nxt_st.cnt = st_ff.cnt + 16'h0001;
                // Pulse length follows the baud band scale
                if (st_ff.cnt == pulse_len - 16'h0001) begin
                    nxt_st.cnt  = '0;
                    nxt_st.mode = st_ff.op.noise_quiet ? RCNC_BITCHK
                                                       : RCNC_RECV;
                end
            end
            default: begin
                nxt_st.mode = RCNC_SLEEP;
            end
        endcase

        // Line drive: demodulated data only while receiving
        case (nxt_st.mode)
            RCNC_RECV: begin
                nxt_st.dout = demod_data;
                nxt_st.doe  = 1'b1;
            end
            RCNC_ENDPLS: begin
                nxt_st.dout = 1'b1;
                nxt_st.doe  = 1'b1;
            end
            default: begin
                // Released line is pulled High
                nxt_st.dout = 1'b1;
                nxt_st.doe  = 1'b0;
            end
        endcase

        // Decoded settings, registered so outputs come from flops
        nxt_st.chk_bits = bits_of(nxt_st.op.check_count);
        nxt_st.scale    = scale_of(nxt_st.op.baud_band);
        nxt_st.lmin = 9'({3'h0, nxt_st.lim.lim_lower} * nxt_st.scale);
        nxt_st.lmax = 9'({3'h0, nxt_st.lim.lim_upper} * nxt_st.scale);
        nxt_st.lbad = (nxt_st.lim.lim_lower < LIM_MIN_FLOOR);
        // Activity flag kept in a flop so the pin has no decode glitch
        nxt_st.act  = (nxt_st.mode != RCNC_SLEEP);
    end

    // Reset loads the documented defaults and starts in start-up mode
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff          <= '0;
            st_ff.mode     <= RCNC_STARTUP;
            st_ff.op       <= OPSET_DEFAULT;
            st_ff.lim      <= LIMIT_DEFAULT;
            st_ff.dout     <= 1'b1;
            st_ff.act      <= 1'b1;
            st_ff.chk_bits <= 4'h3;
            st_ff.scale    <= 4'h8;
            st_ff.lmin     <= 9'h0A8;
            st_ff.lmax     <= 9'h148;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign mode               = st_ff.mode;
    assign ic_active          = st_ff.act;
    assign dline_out          = st_ff.dout;
    assign dline_oe           = st_ff.doe;
    assign supply_dip_pattern = st_ff.rm;
    assign modulation_select  = st_ff.op.modulation_select;
    assign check_bits         = st_ff.chk_bits;
    assign limit_scale        = st_ff.scale;
    assign lim_min_cyc        = st_ff.lmin;
    assign lim_max_cyc        = st_ff.lmax;
    assign lim_min_bad        = st_ff.lbad;

endmodule

// >>> tb/rcnc_host_model.sv
// Host model: sends configuration and OFF frames and drives the polling
// override pin. Assumes the bench merges host and block drive of DATA.
`timescale 1ns/100ps
module rcnc_host_model (
    // Clock
    input  wire logic core_clk,
    // Frame timing and host drive of DATA
    output logic      frame_start,
    output logic      bit_stb,
    output logic      host_oe,
    output logic      host_bit,
    // Polling override, low keeps the block out of sleep
    output logic      polling_on_n
);
    // Idle host: line released, polling allowed
    initial begin
        frame_start = 1'b0;
        bit_stb = 1'b0;
        host_oe = 1'b0;
        host_bit = 1'b0;
        polling_on_n = 1'b1;
    end

    // Bit 1 leaves first; the caller picks the stop bit, 0 unless refused
    task automatic send_frame(input logic [14:0] f);
        @(posedge core_clk);
        frame_start <= 1'b1;
        for (int i = 14; i >= 0; i--) begin
            @(posedge core_clk);
            frame_start <= 1'b0;
            bit_stb <= 1'b1;
            host_oe <= 1'b1;
            host_bit <= f[i];
        end
        @(posedge core_clk);
        bit_stb <= 1'b0;
        host_oe <= 1'b0;
        host_bit <= ~f[0]; // Released bit shows no stale value
    endtask

    // Low for controlled suppression, high again to resume polling
    task automatic set_override(input logic lvl);
        @(posedge core_clk);
        polling_on_n <= lvl;
    endtask
endmodule

// >>> tb/rcnc_top_properties.sv
// Checker of the noise control block, watching top-level ports only.
// Assumes a single clock domain; bound into every rcnc_top instance.
`timescale 1ns/100ps
module rcnc_top_checker #(
    parameter int unsigned PULSE_UNIT_CYC = 8
) (
    // Clock and reset
    input wire logic                 core_clk,
    input wire logic                 nrst,
    // Watched ports
    input wire logic                 dline_out,
    input wire logic                 dline_oe,
    input wire logic                 polling_on_n,
    input wire logic                 demod_data,
    input wire logic                 stream_end,
    input wire logic                 last_high,
    input wire logic                 chk_ok,
    input wire logic                 chk_fail,
    input rcnc_pkg::rcnc_mode_e      mode,
    input wire logic [3:0]           check_bits,
    input wire logic [3:0]           limit_scale,
    input wire logic [8:0]           lim_min_cyc,
    input wire logic                 lim_min_bad
);
    import rcnc_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // Cycles spent in the end pulse, so its length can be judged
    logic [8:0] pls_cnt_ff;
    logic [8:0] nxt_pls_cnt;
    always_comb begin
        nxt_pls_cnt = (mode == RCNC_ENDPLS) ? pls_cnt_ff + 9'h001 : 9'h000;
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pls_cnt_ff <= 9'h000;
        end else begin
            pls_cnt_ff <= nxt_pls_cnt;
        end
    end

    bitchk_quiet_a: assert property (mode == RCNC_BITCHK |->
        !dline_oe && dline_out) else $error("DATA not high in bit check");
    recv_pass_a: assert property (mode == RCNC_RECV &&
        $past(mode) == RCNC_RECV |-> dline_oe &&
        dline_out == $past(demod_data)) else $error("data not passed");
    chk_return_a: assert property (mode == RCNC_BITCHK &&
        chk_ok |=> mode == RCNC_RECV) else $error("no return to receive");
    sleep_wake_a: assert property (mode == RCNC_SLEEP &&
        !polling_on_n |=> mode == RCNC_STARTUP) else $error("no wake");
    chk_fail_a: assert property (mode == RCNC_BITCHK &&
        chk_fail && !chk_ok |=>
        mode == ($past(polling_on_n) ? RCNC_SLEEP : RCNC_STARTUP))
        else $error("wrong mode after failed check");
    end_pulse_a: assert property (mode == RCNC_RECV &&
        stream_end && last_high |=> mode == RCNC_ENDPLS && dline_oe &&
        dline_out)
        else $error("no end pulse");
    pulse_len_a: assert property ($past(mode) == RCNC_ENDPLS &&
        mode != RCNC_ENDPLS |-> pls_cnt_ff == PULSE_UNIT_CYC * limit_scale)
        else $error("end pulse length wrong");
    field_codes_a: assert property (check_bits inside
        {4'h0, 4'h3, 4'h6, 4'h9} && limit_scale inside
        {4'h1, 4'h2, 4'h4, 4'h8}) else $error("illegal decoded field");
    lim_floor_a: assert property (lim_min_bad ==
        (lim_min_cyc < 10 * limit_scale)) else $error("limit floor flag");
endmodule

bind rcnc_top rcnc_top_checker #(.PULSE_UNIT_CYC(PULSE_UNIT_CYC)) u_chk (
    .core_clk(core_clk), .nrst(nrst), .dline_out(dline_out),
    .dline_oe(dline_oe), .polling_on_n(polling_on_n),
    .demod_data(demod_data), .stream_end(stream_end),
    .last_high(last_high), .chk_ok(chk_ok), .chk_fail(chk_fail),
    .mode(mode), .check_bits(check_bits), .limit_scale(limit_scale),
    .lim_min_cyc(lim_min_cyc), .lim_min_bad(lim_min_bad));

// >>> tb/test_receiver_config_and_noise_control.sv
// Self-checking bench of the noise control block with a host model.
// Assumes shortened start-up, pulse and sleep units for run time.
`timescale 1ns/100ps
module test_receiver_config_and_noise_control;
    import rcnc_pkg::*;
    typedef struct packed {
        logic [11:0] pay;
        logic [3:0]  scale;
        logic [3:0]  bits;
    } rcnc_row_s;
    logic core_clk = 1'b0, nrst = 1'b0, dline_in, dline_out, dline_oe;
    logic frame_start, bit_stb, polling_on_n, host_oe, host_bit;
    logic demod_data, stream_end, last_high, chk_ok, chk_fail, supply_dip;
    logic ic_active, supply_dip_pattern, modulation_select, lim_min_bad;
    logic [3:0] check_bits, limit_scale;
    logic [8:0] lim_min_cyc, lim_max_cyc;
    rcnc_mode_e mode;
    int failures = 0, total_checks = 0, cyc = 0, naps = 0, nap0 = 0;
    // Every band and check count, modulation both ways
    rcnc_row_s rows [4] = '{'{12'h099, 4'h8, 4'h0}, '{12'h519, 4'h4, 4'h3},
                            '{12'hA19, 4'h2, 4'h6}, '{12'hF99, 4'h1, 4'h9}};

    // DATA is pulled high when nobody drives it
    assign dline_in = host_oe ? host_bit : (dline_oe ? dline_out : 1'b1);

    rcnc_host_model u_host (.core_clk(core_clk), .frame_start(frame_start),
        .bit_stb(bit_stb), .host_oe(host_oe), .host_bit(host_bit),
        .polling_on_n(polling_on_n));
    rcnc_top #(.STARTUP_CYC(4), .PULSE_UNIT_CYC(2), .SLEEP_UNIT_CYC(4)) u_dut (
        .core_clk(core_clk), .nrst(nrst), .dline_in(dline_in),
        .dline_out(dline_out), .dline_oe(dline_oe), .frame_start(frame_start),
        .bit_stb(bit_stb), .polling_on_n(polling_on_n),
        .demod_data(demod_data), .stream_end(stream_end),
        .last_high(last_high), .chk_ok(chk_ok), .chk_fail(chk_fail),
        .supply_dip(supply_dip), .mode(mode), .ic_active(ic_active),
        .supply_dip_pattern(supply_dip_pattern),
        .modulation_select(modulation_select), .check_bits(check_bits),
        .limit_scale(limit_scale), .lim_min_cyc(lim_min_cyc),
        .lim_max_cyc(lim_max_cyc), .lim_min_bad(lim_min_bad));

    initial begin
        forever #4 core_clk = ~core_clk;
    end
    // Noise-like demodulator output, a sleep monitor and the hang guard
    always @(posedge core_clk) begin
        demod_data <= cyc[0];
        // Cycles spent asleep, seen before this edge's update
        if (mode === RCNC_SLEEP) naps++;
        cyc++;
        if (cyc == 20000) begin
            failures++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp,
                       input string what);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Bounded wait; a miss shows up as a mode mismatch
    task automatic wait_mode(input rcnc_mode_e m);
        for (int i = 0; i < 200 && mode !== m; i++) tick(1);
        chk({6'h00, mode}, {6'h00, m}, "mode wait");
    endtask
    task automatic pulse(input int which, input logic lh);
        @(posedge core_clk);
        chk_ok <= (which == 0);
        chk_fail <= (which == 1);
        stream_end <= (which == 2);
        supply_dip <= (which == 3);
        last_high <= lh;
        @(posedge core_clk);
        {chk_ok, chk_fail, stream_end, supply_dip} <= 4'h0;
        tick(1);
    endtask

    initial begin
        stream_end <= 1'b0;
        last_high  <= 1'b0;
        chk_ok     <= 1'b0;
        chk_fail   <= 1'b0;
        supply_dip <= 1'b0;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            u_host.send_frame({2'b01, rows[i].pay, 1'b0});
            tick(3);
            chk(9'(limit_scale), 9'(rows[i].scale), "scale");
            chk(9'(check_bits), 9'(rows[i].bits), "bits");
            chk(9'(modulation_select), 9'(rows[i].pay[7]),
                "mod");
        end
        $display("field table done");
        u_host.send_frame({2'b01, 12'h019, 1'b1});
        tick(3);
        chk(9'(check_bits), 9'h009, "stop bit 1 kept");
        u_host.send_frame({2'b00, 6'h09, 6'h3F, 1'b0});
        tick(3);
        chk(lim_min_cyc, 9'h009, "lim min");
        chk(lim_max_cyc, 9'h03F, "lim max");
        chk(9'(lim_min_bad), 9'h001, "floor");
        u_host.send_frame({2'b01, 12'h119, 1'b0});
        tick(3);
        chk(lim_max_cyc, 9'h1F8, "lim max scaled");
        $display("limits done");
        wait_mode(RCNC_BITCHK);
        pulse(0, 1'b0);
        wait_mode(RCNC_RECV);
        pulse(2, 1'b0);
        chk(9'(mode), 9'(RCNC_BITCHK), "auto quiet");
        chk(9'({dline_oe, dline_out}), 9'h001, "DATA high");
        pulse(0, 1'b0);
        chk(9'(mode), 9'(RCNC_RECV), "check ok");
        pulse(2, 1'b1);
        chk(9'(mode), 9'(RCNC_ENDPLS), "end pulse");
        chk(9'({dline_oe, dline_out}), 9'h003, "pulse high");
        wait_mode(RCNC_BITCHK);
        pulse(0, 1'b0);
        $display("auto suppression done");
        u_host.send_frame({2'b01, 12'h118, 1'b0});
        tick(3);
        pulse(2, 1'b0);
        chk(9'(mode), 9'(RCNC_RECV), "noise kept");
        chk(9'(dline_oe), 9'h001, "noise driven");
        u_host.set_override(1'b0);
        nap0 = naps;
        u_host.send_frame({1'b1, 14'h0000});
        wait_mode(RCNC_BITCHK);
        chk(9'(naps != nap0), 9'h000, "sleep skipped");
        pulse(1, 1'b0);
        chk(9'(mode), 9'(RCNC_STARTUP), "retry");
        wait_mode(RCNC_BITCHK);
        pulse(0, 1'b0);
        chk(9'(mode), 9'(RCNC_RECV), "back to receive");
        $display("controlled suppression done");
        u_host.set_override(1'b1);
        // Sleep count 1 with stretch: 8 units of 4 cycles at the least
        u_host.send_frame({2'b01, 12'h107, 1'b0});
        tick(3);
        nap0 = naps;
        u_host.send_frame({1'b1, 14'h0000});
        wait_mode(RCNC_BITCHK);
        chk(9'(naps - nap0 >= 32), 9'h001, "slept");
        pulse(1, 1'b0);
        chk(9'(mode), 9'(RCNC_SLEEP), "fail sleeps");
        chk(9'(ic_active), 9'h000, "inactive");
        u_host.set_override(1'b0);
        tick(2);
        chk(9'(mode), 9'(RCNC_STARTUP), "wake");
        $display("sleep done");
        pulse(3, 1'b0);
        chk(9'(supply_dip_pattern), 9'h001, "marker");
        u_host.send_frame({2'b01, 12'h119, 1'b0});
        u_host.send_frame({2'b00, 12'h569, 1'b0});
        tick(3);
        chk(9'(supply_dip_pattern), 9'h000, "marker cleared");
        @(posedge core_clk);
        nrst <= 1'b0;
        tick(1);
        chk(9'(mode), 9'(RCNC_STARTUP), "reset mode");
        chk(9'(check_bits), 9'h003, "reset bits");
        chk(9'(limit_scale), 9'h008, "reset scale");
        chk(lim_min_cyc, 9'h0A8, "reset min");
        chk(lim_max_cyc, 9'h148, "reset max");
        chk(9'(modulation_select), 9'h000, "reset mod");
        chk(9'({dline_oe, dline_out}), 9'h001, "reset line");
        chk(9'(ic_active), 9'h001, "reset active");
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        wait_mode(RCNC_BITCHK);
        $display("reset done");
        close_out();
    end
endmodule
